// ### core/tcc_regs.svh
// Register map, field positions and reset values of the capture/compare timer.
// Assumes a 32-bit AXI4-Lite bus; each byte register sits in one aligned word.
`ifndef TCC_REGS_SVH
`define TCC_REGS_SVH
// Register indices; byte address is four times the index
`define TCC_IDX_CNT_HI 12'hf00
`define TCC_IDX_CNT_LO 12'hf01
`define TCC_IDX_RLD_HI 12'hf02
`define TCC_IDX_RLD_LO 12'hf03
`define TCC_IDX_CAP_HI 12'hf04
`define TCC_IDX_CAP_LO 12'hf05
`define TCC_IDX_CTL2 12'hf06
`define TCC_IDX_CTL 12'hf07
// Control fields
`define TCC_CTL_EN 7
`define TCC_CTL_POL 6
`define TCC_CTL_PRE_LSB 3
`define TCC_CTL_MODE_LSB 0
`define TCC_CTL2_MODE_HI 7
`define TCC_CTL2_SRC_LSB 5
`define TCC_CTL2_OUT_EN 4
`define TCC_CTL2_CAUSE 0
// Reset and restart values
`define TCC_CNT_RST 16'h0001
`define TCC_RLD_RST 16'hffff
`define TCC_CAP_RST 16'h0000
`define TCC_RESTART 16'h0001
`define TCC_CTL_RST 8'h00
`define TCC_CTL2_RST 8'h00
`endif

// ### core/tcc_pkg.sv
// Types of the capture/compare timer.
// Assumes the register constants of tcc_regs.svh.
package tcc_pkg;
   typedef enum logic [3:0] {
      TCC_M_CAPTURE = 4'h3,
      TCC_M_COMPARE = 4'h5,
      TCC_M_GATED = 4'h6,
      TCC_M_RESTART = 4'h8
   } tcc_mode_t;
   typedef enum logic [1:0] {
      TCC_SRC_BOTH = 2'h0,
      TCC_SRC_INPUT = 2'h1,
      TCC_SRC_RELOAD = 2'h2,
      TCC_SRC_ALSO = 2'h3
   } tcc_src_t;
   typedef struct packed {
      logic en;
      logic pol;
      logic [2:0] pre;
      logic [2:0] mode;
   } tcc_ctl_t;
   typedef struct packed {
      logic mode_hi;
      logic [1:0] src;
      logic out_en;
      logic [3:0] rsv;
   } tcc_ctl2_t;
endpackage

// ### core/tcc_timer.sv
// 16-bit capture/compare/gated timer with an AXI4-Lite register slave.
// Assumes one clock clk_sys, synchronous low reset, asynchronous timer pin.
//
// Function
// - Capture mode copies count into capture pair on selected input edge.
// - Input polarity bit picks rising or falling capture edge.
// - Capture raises interrupt, sets capture cause flag, count keeps running.
// - Capture mode reaching reload raises interrupt, counting continues.
// - Reload interrupt in capture mode clears capture cause flag.
// - Interrupt source select restricts capture-mode interrupt to capture or reload.
// - Restart mode capture raises interrupt, sets flag, count restarts at one.
// - Restart mode reaching compare raises interrupt, restarts at one, clears flag.
// - Restart mode needs the mode high bit in second control register.
// - Compare mode match raises interrupt, counting continues without restart.
// - Compare match toggles timer output when output function enabled.
// - Compare mode wraps from FFFFH to 0000H.
// - Timer output starts at level programmed while timer disabled.
// - Gated mode counts only while input is at active level.
// - Gated mode interrupts on input deassertion and on reload.
// - Gated reload raises interrupt and restarts count at one.
// - Gated reload toggles timer output when output function enabled.
// - Written start count serves first pass only in gated and restart modes; later passes start at one.
// - Interrupt source select restricts gated interrupt to deassertion or reload.
// - Enabled count high read latches low byte for following low read.
// - Reload high write is held until reload low write updates both.
//
// Added by the designer: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "tcc_regs.svh"
module tcc_timer #(
   parameter int CNT_W = 16,
   parameter int ADDR_W = 14
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic tmr_in,
   output logic tmr_out,
   output logic tmr_out_oe,
   output logic tmr_irq
);
   generate
      if (CNT_W != 16 || ADDR_W < 14) begin : g_chk
         $error("tcc_timer serves only CNT_W 16 and ADDR_W of 14 or more");
      end
   endgenerate
   tcc_pkg::tcc_ctl_t ctl_r;
   tcc_pkg::tcc_ctl2_t ctl2_r;
   logic [15:0] cnt_r, cnt_nxt, rld_r, cap_r;
   logic [7:0] rld_hold_r, lo_hold_r, pre_r, pre_mask;
   logic flag_r, irq_r, tout_r, oe_r;
   logic tin_s1_r, tin_s2_r, tin_d_r;
   logic awready_r, bvalid_r, arready_r, rvalid_r;
   logic [1:0] bresp_r, rresp_r;
   logic [31:0] rdata_r;
   logic wr_en, rd_en, wr_ok, rd_ok;
   logic [11:0] wr_idx, rd_idx;
   logic [7:0] wb;
   logic [3:0] mode;
   logic tick, act, cap_edge, deassert, cap_ev, rel_ev, cap_mode, cnt_wr;
   logic irq_nxt, toggle, src_in, src_rel;
   // Bus slave
   assign wr_en = s_axi_awvalid && s_axi_wvalid && awready_r;
   assign rd_en = s_axi_arvalid && arready_r;
   assign wr_idx = s_axi_awaddr[13:2];
   assign rd_idx = s_axi_araddr[13:2];
   assign wb = s_axi_wdata[7:0];
   assign wr_ok = wr_idx >= `TCC_IDX_CNT_HI && wr_idx <= `TCC_IDX_CTL;
   assign rd_ok = rd_idx >= `TCC_IDX_CNT_HI && rd_idx <= `TCC_IDX_CTL;

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         awready_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= 2'h0;
      end else begin
         awready_r <= s_axi_awvalid && s_axi_wvalid && !awready_r && !bvalid_r;
         if (wr_en) begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_ok ? 2'h0 : 2'h2;
         end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b0;
         rresp_r <= 2'h0;
         rdata_r <= 32'h0;
      end else begin
         arready_r <= s_axi_arvalid && !arready_r && !rvalid_r;
         if (rd_en) begin
            rvalid_r <= 1'b1;
            rresp_r <= rd_ok ? 2'h0 : 2'h2;
            case (rd_idx)
               `TCC_IDX_CNT_HI: rdata_r <= {24'h0, cnt_r[15:8]};
               `TCC_IDX_CNT_LO: rdata_r <= {24'h0, ctl_r.en ? lo_hold_r : cnt_r[7:0]};
               `TCC_IDX_RLD_HI: rdata_r <= {24'h0, rld_r[15:8]};
               `TCC_IDX_RLD_LO: rdata_r <= {24'h0, rld_r[7:0]};
               `TCC_IDX_CAP_HI: rdata_r <= {24'h0, cap_r[15:8]};
               `TCC_IDX_CAP_LO: rdata_r <= {24'h0, cap_r[7:0]};
               `TCC_IDX_CTL2: rdata_r <= {24'h0, ctl2_r[7:1], flag_r};
               `TCC_IDX_CTL: rdata_r <= {24'h0, ctl_r};
               default: rdata_r <= 32'h0;
            endcase
         end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
         end
      end
   end
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         lo_hold_r <= 8'h00;
      end else if (rd_en && rd_idx == `TCC_IDX_CNT_HI && ctl_r.en) begin
         lo_hold_r <= cnt_r[7:0];
      end
   end
   // Control registers
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         ctl_r <= `TCC_CTL_RST;
         ctl2_r <= `TCC_CTL2_RST;
      end else if (wr_en && s_axi_wstrb[0]) begin
         if (wr_idx == `TCC_IDX_CTL) begin
            ctl_r <= wb;
         end
         if (wr_idx == `TCC_IDX_CTL2) begin
            ctl2_r <= {wb[7:4], 4'h0};
         end
      end
   end
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         rld_hold_r <= 8'(`TCC_RLD_RST >> 8);
         rld_r <= `TCC_RLD_RST;
      end else if (wr_en && s_axi_wstrb[0]) begin
         if (wr_idx == `TCC_IDX_RLD_HI) begin
            rld_hold_r <= wb;
         end
         if (wr_idx == `TCC_IDX_RLD_LO) begin
            rld_r <= {rld_hold_r, wb};
         end
      end
   end
   // Input pin synchroniser
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         tin_s1_r <= 1'b0;
         tin_s2_r <= 1'b0;
         tin_d_r <= 1'b0;
      end else begin
         tin_s1_r <= tmr_in;
         tin_s2_r <= tin_s1_r;
         tin_d_r <= tin_s2_r;
      end
   end
   assign mode = {ctl2_r.mode_hi, ctl_r.mode};
   assign cap_mode = mode == tcc_pkg::TCC_M_CAPTURE || mode == tcc_pkg::TCC_M_RESTART;
   assign act = tin_s2_r == ctl_r.pol;
   assign cap_edge = ctl_r.pol ? (tin_s2_r && !tin_d_r) : (!tin_s2_r && tin_d_r);
   assign deassert = tin_d_r == ctl_r.pol && !act;
   assign cap_ev = ctl_r.en && cap_mode && cap_edge;
   assign pre_mask = ~(8'hff << ctl_r.pre);
   assign tick = ctl_r.en && (pre_r & pre_mask) == pre_mask
      && (mode != tcc_pkg::TCC_M_GATED || act);
   assign rel_ev = tick && cnt_r == rld_r;
   assign cnt_wr = wr_en && s_axi_wstrb[0]
      && (wr_idx == `TCC_IDX_CNT_HI || wr_idx == `TCC_IDX_CNT_LO);
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         pre_r <= 8'h00;
      end else if (!ctl_r.en || tick) begin
         pre_r <= 8'h00;
      end else begin
         pre_r <= pre_r + 8'h01;
      end
   end

   always_comb begin
      cnt_nxt = cnt_r;
      case (mode)
         tcc_pkg::TCC_M_RESTART: begin
            if (cap_ev) begin
               cnt_nxt = `TCC_RESTART;
            end else if (rel_ev) begin
               cnt_nxt = `TCC_RESTART;
            end else if (tick) begin
               cnt_nxt = cnt_r + 16'h0001;
            end
         end
         tcc_pkg::TCC_M_GATED: begin
            if (rel_ev) begin
               cnt_nxt = `TCC_RESTART;
            end else if (tick) begin
               cnt_nxt = cnt_r + 16'h0001;
            end
         end
         tcc_pkg::TCC_M_CAPTURE, tcc_pkg::TCC_M_COMPARE: begin
            if (tick) begin
               cnt_nxt = cnt_r + 16'h0001;
            end
         end
         default: cnt_nxt = cnt_r;
      endcase
      if (cnt_wr && wr_idx == `TCC_IDX_CNT_HI) begin
         cnt_nxt[15:8] = wb;
      end
      if (cnt_wr && wr_idx == `TCC_IDX_CNT_LO) begin
         cnt_nxt[7:0] = wb;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         cnt_r <= `TCC_CNT_RST;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end
   // capture copy, capture wins over a clearing write
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         cap_r <= `TCC_CAP_RST;
      end else if (cap_ev) begin
         cap_r <= cnt_r;
      end else if (wr_en && s_axi_wstrb[0] && wr_idx == `TCC_IDX_CAP_HI) begin
         cap_r[15:8] <= wb;
      end else if (wr_en && s_axi_wstrb[0] && wr_idx == `TCC_IDX_CAP_LO) begin
         cap_r[7:0] <= wb;
      end
   end
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         flag_r <= 1'b0;
      end else if (cap_ev) begin
         flag_r <= 1'b1;
      end else if (cap_mode && rel_ev) begin
         flag_r <= 1'b0;
      end
   end
   assign src_in = ctl2_r.src != tcc_pkg::TCC_SRC_RELOAD;
   assign src_rel = ctl2_r.src != tcc_pkg::TCC_SRC_INPUT;
   always_comb begin
      irq_nxt = 1'b0;
      case (mode)
         tcc_pkg::TCC_M_CAPTURE, tcc_pkg::TCC_M_RESTART:
            irq_nxt = (cap_ev && src_in) || (rel_ev && src_rel);
         tcc_pkg::TCC_M_GATED:
            irq_nxt = (ctl_r.en && deassert && src_in) || (rel_ev && src_rel);
         tcc_pkg::TCC_M_COMPARE: irq_nxt = rel_ev;
         default: irq_nxt = 1'b0;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= irq_nxt;
      end
   end
   assign toggle = ctl2_r.out_en && rel_ev
      && (mode == tcc_pkg::TCC_M_COMPARE || mode == tcc_pkg::TCC_M_GATED);
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         tout_r <= 1'b0;
         oe_r <= 1'b0;
      end else begin
         oe_r <= ctl2_r.out_en;
         if (!ctl_r.en) begin
            tout_r <= ctl_r.pol;
         end else if (toggle) begin
            tout_r <= !tout_r;
         end
      end
   end

   assign s_axi_awready = awready_r;
   assign s_axi_wready = awready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rresp = rresp_r;
   assign s_axi_rdata = rdata_r;
   assign tmr_out = tout_r;
   assign tmr_out_oe = oe_r;
   assign tmr_irq = irq_r;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   a_cap_copy: assert property (cap_ev |=> cap_r == $past(cnt_r))
      else $error("capture value not taken");
   a_cap_flag_set: assert property (cap_ev |=> flag_r ##1 (flag_r || $past(rel_ev)))
      else $error("capture cause flag not set");
   a_rel_flag_clr: assert property (cap_mode && rel_ev && !cap_ev |=> !flag_r)
      else $error("cause flag not cleared on reload");
   a_restart_one: assert property (mode == tcc_pkg::TCC_M_RESTART && cap_ev && !cnt_wr
      |=> cnt_r == 16'h0001)
      else $error("restart did not load one");
   a_cmp_run: assert property (mode == tcc_pkg::TCC_M_COMPARE && rel_ev && !cnt_wr
      |=> cnt_r == $past(cnt_r) + 16'h0001)
      else $error("compare match altered count");
   a_cmp_toggle: assert property (toggle |=> tout_r != $past(tout_r))
      else $error("output did not toggle");
   a_cmp_wrap: assert property (mode == tcc_pkg::TCC_M_COMPARE && tick && cnt_r == 16'hffff
      && !cnt_wr |=> cnt_r == 16'h0000)
      else $error("count did not wrap");
   a_gate_hold: assert property (mode == tcc_pkg::TCC_M_GATED && !act && !cnt_wr
      |=> $stable(cnt_r))
      else $error("gated count moved while inactive");
   a_gate_irq: assert property (mode == tcc_pkg::TCC_M_GATED && ctl_r.en && deassert
      && src_in |=> tmr_irq)
      else $error("deassertion gave no interrupt");
   a_src_mask: assert property (ctl2_r.src == tcc_pkg::TCC_SRC_RELOAD && cap_ev && !rel_ev
      |=> !tmr_irq)
      else $error("masked capture raised interrupt");
   a_reload_pair: assert property (wr_en && wr_idx == `TCC_IDX_RLD_HI |=> $stable(rld_r))
      else $error("reload updated on high write");
   a_bus_resp: assert property (wr_en |=> s_axi_bvalid)
      else $error("write not answered");
   c_capture: cover property (mode == tcc_pkg::TCC_M_CAPTURE && cap_ev ##1 tmr_irq);
   c_restart_rel: cover property (mode == tcc_pkg::TCC_M_RESTART && rel_ev);
   c_gated_deassert: cover property (mode == tcc_pkg::TCC_M_GATED && deassert ##1 tmr_irq);
   c_cmp_toggle: cover property (mode == tcc_pkg::TCC_M_COMPARE && toggle);
endmodule

// ### verif/tcc_src_model.sv
// Signal source model that drives the timer input pin.
// Assumes the bench sets the wanted level and a settle delay in cycles.
`timescale 1ns/10ps
module tcc_src_model (
   input wire logic clk_sys,
   input wire logic src_lvl,
   input wire logic [3:0] src_dly,
   output logic tmr_in
);
   logic [3:0] cnt_r = 4'h0;
   initial tmr_in = 1'b0;
   // Level follows the request after the delay, off the clock edge
   always @(posedge clk_sys) begin
      if (src_lvl === tmr_in) begin
         cnt_r <= 4'h0;
      end else if (cnt_r >= src_dly) begin
         cnt_r <= 4'h0;
         tmr_in <= #1.3 src_lvl;
      end else begin
         cnt_r <= cnt_r + 4'h1;
      end
   end
endmodule

// ### verif/test_timer_capture_compare_gated.sv
// Self-checking bench of the capture/compare/gated timer.
// Assumes tcc_timer, the register header and the source model.
`timescale 1ns/10ps
`include "tcc_regs.svh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin mismatches++; \
$display("BAD %0t got %h exp %h", $time, (a), (e)); end end
module test_timer_capture_compare_gated;
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   logic [13:0] s_axi_awaddr = 14'h0;
   logic [13:0] s_axi_araddr = 14'h0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic [31:0] s_axi_rdata;
   logic tmr_in, tmr_out, tmr_out_oe, tmr_irq, o;
   logic src_lvl = 1'b0;
   logic [3:0] src_dly = 4'h0;
   logic [7:0] d, h;
   int mismatches = 0, tests_run = 0, n;

   tcc_timer u_dut (.clk_sys(clk_sys), .rstn(rstn), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .tmr_in(tmr_in), .tmr_out(tmr_out),
      .tmr_out_oe(tmr_out_oe), .tmr_irq(tmr_irq));
   tcc_src_model u_src (.clk_sys(clk_sys), .src_lvl(src_lvl), .src_dly(src_dly),
      .tmr_in(tmr_in));

   initial begin
      forever #2 clk_sys = ~clk_sys;
   end

   task automatic wr(input logic [11:0] i, input logic [7:0] v);
      logic a, w;
      a = 1'b0;
      w = 1'b0;
      s_axi_awaddr <= {i, 2'b00};
      s_axi_wdata <= {24'h0, v};
      s_axi_wstrb <= 4'h1;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!(a && w)) begin
         @(posedge clk_sys);
         if (!a && s_axi_awready === 1'b1) begin
            a = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w && s_axi_wready === 1'b1) begin
            w = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      s_axi_bready <= 1'b1;
      while (s_axi_bvalid !== 1'b1) @(posedge clk_sys);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] i);
      s_axi_araddr <= {i, 2'b00};
      s_axi_arvalid <= 1'b1;
      do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b1;
      while (s_axi_rvalid !== 1'b1) @(posedge clk_sys);
      d = s_axi_rdata[7:0];
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   // Cycles until an interrupt pulse, or lim
   task automatic wirq(input int lim);
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (tmr_irq !== 1'b1 && n < lim);
   endtask

   // Disabled setup: control, count, reload, capture pair
   task automatic setup(input logic [7:0] c, input logic [15:0] cnt, input logic [15:0] rl);
      wr(`TCC_IDX_CTL, c);
      wr(`TCC_IDX_CNT_HI, cnt[15:8]);
      wr(`TCC_IDX_CNT_LO, cnt[7:0]);
      wr(`TCC_IDX_RLD_HI, rl[15:8]);
      wr(`TCC_IDX_RLD_LO, rl[7:0]);
      wr(`TCC_IDX_CAP_HI, 8'h00);
      wr(`TCC_IDX_CAP_LO, 8'h00);
   endtask

   task automatic t_reset;
      rd(`TCC_IDX_CNT_LO);
      `CHK(d, 8'h01)
      rd(`TCC_IDX_RLD_LO);
      `CHK(d, 8'hff)
      rd(`TCC_IDX_CAP_HI);
      `CHK(d, 8'h00)
      rd(`TCC_IDX_CTL2);
      `CHK(d, 8'h00)
      rd(12'h000);
      `CHK(resp, 2'h2)
      wr(12'h000, 8'h5a);
      `CHK(resp, 2'h2)
      $display("done reset");
   endtask

   task automatic t_capture;
      wr(`TCC_IDX_CTL2, 8'h00);
      setup(8'h43, 16'h0001, 16'hffff);
      wr(`TCC_IDX_CTL, 8'hc3);
      src_lvl <= 1'b1;
      wirq(40);
      `CHK(n < 40, 1'b1)
      rd(`TCC_IDX_CTL2);
      `CHK(d[0], 1'b1)
      rd(`TCC_IDX_CAP_HI);
      h = d;
      rd(`TCC_IDX_CAP_LO);
      `CHK({h, d} != 16'h0, 1'b1)
      rd(`TCC_IDX_CNT_HI);
      rd(`TCC_IDX_CNT_LO);
      `CHK(d > 8'h10, 1'b1)
      src_lvl <= 1'b0;
      wirq(30);
      `CHK(n, 30)
      setup(8'h43, 16'h0001, 16'h0040);
      wr(`TCC_IDX_CTL, 8'hc3);
      wirq(100);
      `CHK(n < 100, 1'b1)
      rd(`TCC_IDX_CTL2);
      `CHK(d[0], 1'b0)
      rd(`TCC_IDX_CAP_LO);
      `CHK(d, 8'h00)
      rd(`TCC_IDX_CNT_HI);
      rd(`TCC_IDX_CNT_LO);
      `CHK(d > 8'h40, 1'b1)
      wr(`TCC_IDX_CTL2, 8'h20);
      setup(8'h03, 16'h0001, 16'h0040);
      src_lvl <= 1'b1;
      wr(`TCC_IDX_CTL, 8'h83);
      wirq(100);
      `CHK(n, 100)
      src_dly <= 4'h9;
      src_lvl <= 1'b0;
      wirq(50);
      `CHK(n < 50, 1'b1)
      src_dly <= 4'h0;
      wr(`TCC_IDX_CTL2, 8'h40);
      src_lvl <= 1'b1;
      wirq(20);
      src_lvl <= 1'b0;
      wirq(20);
      `CHK(n, 20)
      $display("done capture");
   endtask

   task automatic t_restart;
      wr(`TCC_IDX_CTL2, 8'h00);
      setup(8'h40, 16'h0001, 16'h0030);
      wr(`TCC_IDX_CTL, 8'hc0);
      wirq(100);
      `CHK(n, 100)
      wr(`TCC_IDX_CTL2, 8'h80);
      setup(8'h40, 16'h0001, 16'h0030);
      wr(`TCC_IDX_CTL, 8'hc0);
      wirq(200);
      wirq(200);
      `CHK(n, 48)
      rd(`TCC_IDX_CTL2);
      `CHK(d[0], 1'b0)
      src_lvl <= 1'b1;
      wirq(30);
      `CHK(n < 30, 1'b1)
      wirq(200);
      `CHK(n, 48)
      src_lvl <= 1'b0;
      setup(8'h48, 16'h0001, 16'h0030);
      wr(`TCC_IDX_CTL, 8'hc8);
      wirq(300);
      wirq(300);
      `CHK(n, 96)
      $display("done restart");
   endtask

   task automatic t_compare;
      wr(`TCC_IDX_CTL2, 8'h10);
      setup(8'h45, 16'hfff0, 16'h0020);
      `CHK(tmr_out, 1'b1)
      `CHK(tmr_out_oe, 1'b1)
      wr(`TCC_IDX_CTL, 8'hc5);
      wirq(200);
      `CHK(n < 100, 1'b1)
      @(posedge clk_sys);
      `CHK(tmr_out, 1'b0)
      wirq(70000);
      `CHK(n, 65535)
      @(posedge clk_sys);
      `CHK(tmr_out, 1'b1)
      $display("done compare");
   endtask

   task automatic t_gated;
      wr(`TCC_IDX_CTL2, 8'h10);
      setup(8'h46, 16'h0010, 16'h0020);
      wr(`TCC_IDX_CTL, 8'hc6);
      repeat (20) @(posedge clk_sys);
      rd(`TCC_IDX_CNT_HI);
      `CHK(d, 8'h00)
      rd(`TCC_IDX_CNT_LO);
      `CHK(d, 8'h10)
      o = tmr_out;
      src_lvl <= 1'b1;
      wirq(60);
      `CHK(n < 40, 1'b1)
      @(posedge clk_sys);
      `CHK(tmr_out, ~o)
      wirq(100);
      `CHK(n, 31)
      src_lvl <= 1'b0;
      wirq(20);
      `CHK(n < 20, 1'b1)
      `CHK(tmr_in, 1'b0)
      wr(`TCC_IDX_CTL2, 8'h50);
      src_lvl <= 1'b1;
      wirq(60);
      src_lvl <= 1'b0;
      wirq(20);
      `CHK(n, 20)
      wr(`TCC_IDX_CTL2, 8'h30);
      src_lvl <= 1'b1;
      wirq(80);
      `CHK(n, 80)
      src_lvl <= 1'b0;
      wirq(20);
      `CHK(n < 20, 1'b1)
      $display("done gated");
   endtask

   task automatic print_verdict;
      $display("compares %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Watchdog: the long compare pass is about 66k cycles
   initial begin
      repeat (90000) @(posedge clk_sys);
      mismatches++;
      print_verdict;
   end

   initial begin
      repeat (12) @(posedge clk_sys);
      rstn <= 1'b1;
      t_reset;
      t_capture;
      t_restart;
      t_compare;
      t_gated;
      print_verdict;
   end
endmodule
